/* File: design/inband_code_pkg.sv */
// constants for the receive down-code and spare code detectors
// assumes an 8-bit host port and one received bit per strobe on core_clk_i
package inband_code_pkg;
    // host register addresses and register reset value
    localparam logic [7:0] ADDR_INBAND_CTRL = 8'hB6;
    localparam logic [7:0] ADDR_DOWN_HIGH = 8'hBB;
    localparam logic [7:0] ADDR_DOWN_LOW = 8'hBC;
    localparam logic [7:0] ADDR_SPARE_CTRL = 8'hBD;
    localparam logic [7:0] ADDR_SPARE_HIGH = 8'hBE;
    localparam logic [7:0] ADDR_SPARE_LOW = 8'hBF;
    localparam logic [7:0] ADDR_LINE_STATUS3 = 8'h1E;
    localparam logic [7:0] REG_RESET = 8'h00;
    // field layout
    localparam int LEN_FIELD_MSB = 2;
    localparam logic [2:0] LEN_SEL_LONG = 3'h7;
    localparam int DOWN_SEEN_BIT = 6;
    localparam int SPARE_SEEN_BIT = 7;
    // integration time
    localparam int INTEG_TIME_NS = 36_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int INTEG_CYCLES = INTEG_TIME_NS / CLK_PERIOD_NS;
    localparam int INTEG_W = 20;
    // error tolerance: errors allowed per window of received bits
    localparam logic [7:0] ERR_WIN_LAST = 8'hFF;
    localparam logic [3:0] ERR_LIMIT = 4'h8;
    typedef enum logic [0:0] {
        HUNT = 1'b0,
        LOCKED = 1'b1
    } det_state_t;
endpackage : inband_code_pkg

/* File: design/inband_down_spare_code_detector.sv */
// receive in-band down-code and spare code detectors with their host registers
// assumes host strobes and received bits are synchronous to core_clk_i
`timescale 1ns/1ps

module code_detector_unit #(
    parameter int INTEG_CYCLES = inband_code_pkg::INTEG_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // received stream
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_i,
    // configuration
    input wire logic [7:0] pat_high_i,
    input wire logic [7:0] pat_low_i,
    input wire logic [2:0] len_sel_i,
    input wire logic restart_i,
    // status
    output logic seen_o
);
    inband_code_pkg::det_state_t state;
    inband_code_pkg::det_state_t next_state;
    logic [15:0] shreg;
    logic [3:0] phase;
    logic [7:0] win_cnt;
    logic [3:0] err_cnt;
    logic [inband_code_pkg::INTEG_W-1:0] integ;

    wire is_long = (len_sel_i == inband_code_pkg::LEN_SEL_LONG);
    wire [4:0] plen = is_long ? 5'h10 : {2'h0, len_sel_i} + 5'h01;
    wire [3:0] last_phase = 4'(plen - 5'h01);
    // short codes: upper L bits of the high register, rest ignored
    wire [7:0] short_pat = pat_high_i >> (4'h8 - {1'b0, plen[3:0]});
    wire [15:0] pat16 = is_long ? {pat_high_i, pat_low_i} : {8'h00, short_pat};
    wire [15:0] mask = is_long ? 16'hFFFF : 16'((17'h00001 << plen) - 17'h00001);
    wire [15:0] next_shreg = {shreg[14:0], rx_bit_i};
    wire window_hit = ((next_shreg ^ pat16) & mask) == 16'h0000;
    wire exp_bit = pat16[4'(last_phase - phase)];
    wire bit_err = rx_bit_valid_i && (rx_bit_i != exp_bit);
    wire [3:0] next_err = err_cnt + {3'h0, bit_err};
    wire win_end = rx_bit_valid_i && (win_cnt == inband_code_pkg::ERR_WIN_LAST);
    wire lose_lock = next_err > inband_code_pkg::ERR_LIMIT;
    wire integ_done = integ >= inband_code_pkg::INTEG_W'(INTEG_CYCLES);

    always_comb begin
        next_state = state;
        case (state)
            inband_code_pkg::HUNT: begin
                if (rx_bit_valid_i && window_hit) begin
                    next_state = inband_code_pkg::LOCKED;
                end
            end
            inband_code_pkg::LOCKED: begin
                if (lose_lock) begin
                    next_state = inband_code_pkg::HUNT;
                end
            end
            default: next_state = inband_code_pkg::HUNT;
        endcase
        if (restart_i) begin
            next_state = inband_code_pkg::HUNT;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= inband_code_pkg::HUNT;
            shreg <= 16'h0000;
        end else begin
            state <= next_state;
            if (rx_bit_valid_i) begin
                shreg <= next_shreg;
            end
        end
    end

    // bit phase and error window while locked
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= 4'h0;
            win_cnt <= 8'h00;
            err_cnt <= 4'h0;
        end else if (state != inband_code_pkg::LOCKED || next_state != state) begin
            phase <= 4'h0;
            win_cnt <= 8'h00;
            err_cnt <= 4'h0;
        end else if (rx_bit_valid_i) begin
            phase <= (phase == last_phase) ? 4'h0 : phase + 4'h1;
            win_cnt <= win_cnt + 8'h01;
            err_cnt <= win_end ? 4'h0 : next_err;
        end
    end

    // integration of a continuously present code
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            integ <= '0;
            seen_o <= 1'b0;
        end else if (next_state != inband_code_pkg::LOCKED) begin
            integ <= '0;
            seen_o <= 1'b0;
        end else begin
            if (!integ_done) begin
                integ <= integ + 1'b1;
            end
            seen_o <= integ_done;
        end
    end
endmodule : code_detector_unit

module inband_down_spare_code_detector #(
    parameter int INTEG_CYCLES = inband_code_pkg::INTEG_CYCLES
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // host register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    // received line stream
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_i,
    // status
    output logic down_code_seen_flag_o,
    output logic spare_code_seen_flag_o
);
    logic [7:0] inband_code_ctrl_reg;
    logic [7:0] down_pattern_high_reg;
    logic [7:0] down_pattern_low_reg;
    logic [7:0] spare_length_ctrl_reg;
    logic [7:0] spare_pattern_high_reg;
    logic [7:0] spare_pattern_low_reg;
    logic down_seen;
    logic spare_seen;

    wire sel_ctrl = addr_i == inband_code_pkg::ADDR_INBAND_CTRL;
    wire sel_dn_hi = addr_i == inband_code_pkg::ADDR_DOWN_HIGH;
    wire sel_dn_lo = addr_i == inband_code_pkg::ADDR_DOWN_LOW;
    wire sel_sp_ctrl = addr_i == inband_code_pkg::ADDR_SPARE_CTRL;
    wire sel_sp_hi = addr_i == inband_code_pkg::ADDR_SPARE_HIGH;
    wire sel_sp_lo = addr_i == inband_code_pkg::ADDR_SPARE_LOW;
    wire sel_status = addr_i == inband_code_pkg::ADDR_LINE_STATUS3;
    wire down_restart = wr_i && sel_dn_hi;
    wire spare_restart = wr_i && sel_sp_hi;
    wire [7:0] down_seen_pos = 8'h01 << inband_code_pkg::DOWN_SEEN_BIT;
    wire [7:0] spare_seen_pos = 8'h01 << inband_code_pkg::SPARE_SEEN_BIT;
    wire [7:0] line_status_reg_three = ({8{down_seen}} & down_seen_pos)
        | ({8{spare_seen}} & spare_seen_pos);
    wire [7:0] rd_mux;

    assign rd_mux = sel_ctrl ? inband_code_ctrl_reg :
                    sel_dn_hi ? down_pattern_high_reg :
                    sel_dn_lo ? down_pattern_low_reg :
                    sel_sp_ctrl ? spare_length_ctrl_reg :
                    sel_sp_hi ? spare_pattern_high_reg :
                    sel_sp_lo ? spare_pattern_low_reg :
                    sel_status ? line_status_reg_three : 8'h00;

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            inband_code_ctrl_reg <= inband_code_pkg::REG_RESET;
            down_pattern_high_reg <= inband_code_pkg::REG_RESET;
            down_pattern_low_reg <= inband_code_pkg::REG_RESET;
            spare_length_ctrl_reg <= inband_code_pkg::REG_RESET;
            spare_pattern_high_reg <= inband_code_pkg::REG_RESET;
            spare_pattern_low_reg <= inband_code_pkg::REG_RESET;
        end else if (wr_i) begin
            if (sel_ctrl) inband_code_ctrl_reg <= wr_data_i;
            if (sel_dn_hi) down_pattern_high_reg <= wr_data_i;
            if (sel_dn_lo) down_pattern_low_reg <= wr_data_i;
            if (sel_sp_ctrl) spare_length_ctrl_reg <= wr_data_i;
            if (sel_sp_hi) spare_pattern_high_reg <= wr_data_i;
            if (sel_sp_lo) spare_pattern_low_reg <= wr_data_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= 8'h00;
            down_code_seen_flag_o <= 1'b0;
            spare_code_seen_flag_o <= 1'b0;
        end else begin
            if (rd_i) begin
                rd_data_o <= rd_mux;
            end
            down_code_seen_flag_o <= down_seen;
            spare_code_seen_flag_o <= spare_seen;
        end
    end

    code_detector_unit #(.INTEG_CYCLES(INTEG_CYCLES)) down_det (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .rx_bit_valid_i(rx_bit_valid_i),
        .rx_bit_i(rx_bit_i),
        .pat_high_i(down_pattern_high_reg),
        .pat_low_i(down_pattern_low_reg),
        .len_sel_i(inband_code_ctrl_reg[inband_code_pkg::LEN_FIELD_MSB:0]),
        .restart_i(down_restart),
        .seen_o(down_seen)
    );

    code_detector_unit #(.INTEG_CYCLES(INTEG_CYCLES)) spare_det (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .rx_bit_valid_i(rx_bit_valid_i),
        .rx_bit_i(rx_bit_i),
        .pat_high_i(spare_pattern_high_reg),
        .pat_low_i(spare_pattern_low_reg),
        .len_sel_i(spare_length_ctrl_reg[inband_code_pkg::LEN_FIELD_MSB:0]),
        .restart_i(spare_restart),
        .seen_o(spare_seen)
    );
endmodule : inband_down_spare_code_detector

/* File: verification/code_detector_assertions.sv */
// checker for the detector host port and seen flags
// assumes it is bound to the top module
`timescale 1ns/1ps
module code_detector_checker (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // host port and flags
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rd_data_o,
    input wire logic down_code_seen_flag_o,
    input wire logic spare_code_seen_flag_o
);
    wire rw_reg = addr_i == 8'hB6 || (addr_i >= 8'hBB && addr_i <= 8'hBF);
    wire known = rw_reg || addr_i == 8'h1E;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    a_down_restart: assert property (
        wr_i && addr_i == 8'hBB |-> ##2 !down_code_seen_flag_o [*8]) else $error("down restart");
    a_spare_restart: assert property (
        wr_i && addr_i == 8'hBE |-> ##2 !spare_code_seen_flag_o [*8]) else $error("spare restart");
    a_status_after_restart: assert property (
        wr_i && addr_i == 8'hBE ##2 rd_i && addr_i == 8'h1E |=> !rd_data_o[7])
        else $error("status after restart");
    a_status_spare_bits: assert property (
        rd_i && addr_i == 8'h1E |=> rd_data_o[5:0] == 6'h00) else $error("status low bits");
    a_unmapped_zero: assert property (
        rd_i && !known |=> rd_data_o == 8'h00) else $error("unmapped read");
    a_read_hold: assert property (
        !rd_i |=> $stable(rd_data_o)) else $error("read data moved");
    a_reset_quiet: assert property ($fell(rst_i) |-> rd_data_o == 8'h00
        && !down_code_seen_flag_o && !spare_code_seen_flag_o) else $error("reset state");
    a_write_readback: assert property (
        wr_i && !rd_i && rw_reg ##1 !wr_i ##1 rd_i && addr_i == $past(addr_i, 2)
        |=> rd_data_o == $past(wr_data_i, 3)) else $error("readback");
endmodule : code_detector_checker
bind inband_down_spare_code_detector code_detector_checker u_chk (.*);

/* File: verification/loop_code_source.sv */
// line equipment sending a repeating code, first bit from bit 15
// assumes one strobe per cycle, or every other cycle when slow
`timescale 1ns/1ps
module loop_code_source (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // code setup
    input wire logic [15:0] code_i,
    input wire logic [4:0] len_i,
    input wire logic err_i,
    input wire logic slow_i,
    // line
    output logic bit_valid_o,
    output logic bit_o
);
    logic [4:0] pos;
    logic [6:0] cnt;
    wire go = !slow_i || !bit_valid_o;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pos <= 5'h00;
            cnt <= 7'h00;
            bit_valid_o <= 1'b0;
            bit_o <= 1'b0;
        end else begin
            bit_valid_o <= go;
            // a shorter new length must not leave the position past the code end
            pos <= !go ? pos : (pos + 5'h01 >= len_i) ? 5'h00 : pos + 5'h01;
            cnt <= !go ? cnt : (cnt == 7'h63) ? 7'h00 : cnt + 7'h01;
            // one flipped bit in a hundred when errors are on
            bit_o <= go ? code_i[5'hF - pos] ^ (err_i && cnt == 7'h00) : ~bit_o;
        end
    end
endmodule : loop_code_source

/* File: verification/inband_down_spare_code_detector_tb_top.sv */
// self-checking bench for the down and spare code detectors
// assumes a 20-cycle integration time set by parameter
`timescale 1ns/1ps
`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module inband_down_spare_code_detector_tb_top;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr_i, wr_data_i, d8;
    logic wr_i, rd_i, err, slow;
    logic rd_q = 1'b0;
    wire [7:0] rd_data_o;
    wire down_f, spare_f, bv, bb;
    logic [15:0] code, e;
    logic [16:0] n_e;
    logic [4:0] len;
    // note: status read flag, compare mask, expected value
    logic [16:0] expq[$];
    logic [7:0] map[7] = '{8'hB6, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'h10};
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'hea65;
    initial forever #50 core_clk_i = ~core_clk_i;
    inband_down_spare_code_detector #(.INTEG_CYCLES(20)) u_dut (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
        .rd_data_o(rd_data_o), .rx_bit_valid_i(bv), .rx_bit_i(bb),
        .down_code_seen_flag_o(down_f), .spare_code_seen_flag_o(spare_f));
    loop_code_source u_src (.core_clk_i(core_clk_i), .rst_i(rst_i), .code_i(code),
        .len_i(len), .err_i(err), .slow_i(slow), .bit_valid_o(bv), .bit_o(bb));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge core_clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        expq.push_back({a == 8'h1E, m, v & m});
        @(posedge core_clk_i);
        rd_i <= 1'b0;
    endtask : rd
    task automatic give_verdict;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    always @(posedge core_clk_i) begin
        if (rd_q) begin
            n_e = expq.pop_front();
            `CHECK(rd_data_o & n_e[15:8], n_e[7:0])
            // flag pins are loaded on the same edge as the status read data
            if (n_e[16]) begin
                `CHECK(({spare_f, down_f, 6'h00} & n_e[15:8]), n_e[7:0])
            end
        end
        rd_q <= rd_i;
        cycles++;
        if (cycles == 30000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        {addr_i, wr_data_i, wr_i, rd_i, err, slow} = '0;
        code = 16'h8000;
        len = 5'h01;
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        foreach (map[i]) rd(map[i], 8'hFF, 8'h00);
        foreach (map[i]) begin
            d8 = 8'($random(seed)) & (i == 3 ? 8'h07 : 8'hFF);
            wr(map[i], d8);
            rd(map[i], 8'hFF, i == 6 ? 8'h00 : d8);
        end
        for (int d = 0; d < 2; d++) begin
            for (int n = 0; n < 8; n++) begin
                e = 16'($random(seed));
                code <= e;
                len <= 5'(n == 7 ? 16 : n + 1);
                slow <= n[0];
                wr(d ? 8'hBD : 8'hB6, 8'(n));
                wr(d ? 8'hBF : 8'hBC, n == 7 ? e[7:0] : 8'($random(seed)));
                d8 = 8'(e[15:8] | ((8'h7F >> n) & $random(seed)));
                wr(d ? 8'hBE : 8'hBB, n == 7 ? e[15:8] : d8);
                repeat (120) @(posedge core_clk_i);
                rd(8'h1E, d ? 8'h80 : 8'h40, 8'hFF);
            end
        end
        err <= 1'b1;
        repeat (600) @(posedge core_clk_i);
        rd(8'h1E, 8'h80, 8'h80);
        wr(8'hBE, code[15:8]);
        rd(8'h1E, 8'h80, 8'h00);
        err <= 1'b0;
        slow <= 1'b0;
        wr(8'hB6, 8'h00);
        wr(8'hBB, 8'h80);
        code <= 16'h8000;
        len <= 5'h01;
        repeat (60) @(posedge core_clk_i);
        rd(8'h1E, 8'h40, 8'h40);
        code <= 16'h0000;
        repeat (600) @(posedge core_clk_i);
        rd(8'h1E, 8'h40, 8'h00);
        repeat (3) @(posedge core_clk_i);
        give_verdict();
    end
endmodule : inband_down_spare_code_detector_tb_top
